//--- hw/mtr_relay.sv
// Top level sequencer of the multi-function timing relay
`timescale 1ns/1ps

// Operation
// RL1 - Power-on monitor: control high at power starts
// RL2 - Power-on monitor: no edge, output off
// RL3 - Monitor: each rising edge restarts, output on
// RL4 - Other party re-closes contact within interval
// RL5 - Latching monitor: output on at power-up
// RL6 - Latching monitor: closure starts the interval
// RL7 - Latching monitor: expiry trips, pulses ignored
// RL8 - Latching monitor: only power cycle restarts
// RL9 - On-delay: time from power-up, then on
// RL10 - On-delay: power loss discards elapsed time
// RL11 - Off-delay: on while powered, time at loss
// RL12 - Off-delay: power return cancels the interval
// RL13 - Loss shot: pulse starts at power loss
// RL14 - Loss shot: power return leaves pulse running
// RL15 - Gain shot: pulse at power-up, then off
// RL16 - Gain shot: dropout leaves pulse running
// RL17 - Both-edge shot: pulse at gain and loss
// RL18 - Both-edge shot: running pulse never cut
// RL19 - Function and range from seven-way switches
// RL20 - Lamps: flash timing, steady idle, follow output
// RL21 - Supply debounced; timing continues after loss
// RL22 - Control debounced, edges found synchronously
module mtr_relay
  import mtr_pkg::*;
#(
  parameter int TICK_CYCLES = MTR_TICK_CYCLES, // Cycles per 1 ms step
  parameter int DB_CYCLES = MTR_DB_CYCLES     // Debounce settle cycles
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic supply_sense,
  input wire logic ctrl_in,
  input wire logic [2:0] func_sel,
  input wire logic [2:0] range_sel,
  output mtr_ind_t ind
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mtr_top_st_t st_r;                          // Registered state
  mtr_top_st_t st_nxt;                        // Next state
  logic sup_db;                               // Debounced supply level
  logic ctrl_db;                              // Debounced control level
  logic sup_rise;                             // Supply appeared
  logic sup_fall;                             // Supply lost
  logic ctrl_rise;                            // Control contact closed
  logic busy;                                 // Interval still running
  logic tmr_start;                            // Restart the interval
  logic tmr_stop;                             // Abandon the interval
  logic tmr_expire;                           // Interval completed
  logic tmr_tick;                             // 1 ms step
  logic [MTR_CNT_W-1:0] limit_ms;             // Selected interval

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  // Supply presence filtered before it steers anything
  mtr_debounce #(
    .DB_CYCLES(DB_CYCLES)
  ) u_sup_db (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(supply_sense),
    .level(sup_db)                            // RL21
  );

  // Control contact filtered so bounce gives one edge
  mtr_debounce #(
    .DB_CYCLES(DB_CYCLES)
  ) u_ctrl_db (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(ctrl_in),
    .level(ctrl_db)                           // RL22
  );

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  // Limit follows the range switch of the active setting
  assign limit_ms = mtr_range_ms(st_r.range); // RL19

  // Counter keeps running through supply changes unless the sequencer asserts tmr_stop
  mtr_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(tmr_start),
    .stop(tmr_stop),
    .limit_ms(limit_ms),
    .running(),
    .expire(tmr_expire),
    .ms_tick(tmr_tick)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Filtered levels against their last sampled values
  assign sup_rise = sup_db & ~st_r.sup_prev;
  assign sup_fall = ~sup_db & st_r.sup_prev;
  assign ctrl_rise = ctrl_db & ~st_r.ctrl_prev; // RL22
  // Expiry in this cycle frees the sequencer for a new pulse
  assign busy = (st_r.state == MTR_ST_TIMING) & ~tmr_expire;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // One pass per cycle: events in, relay and timer commands out
  always_comb begin
    st_nxt = st_r;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    st_nxt.sup_prev = sup_db;
    st_nxt.ctrl_prev = ctrl_db;
    // Selector switches through two flops
    st_nxt.sw_meta = {func_sel, range_sel};
    st_nxt.sw_sync = st_r.sw_meta;
    st_nxt.range = st_r.sw_sync[2:0];         // RL19
    if (st_r.sw_sync[5:3] != st_r.func) begin
      // New function: drop everything, replay power-up
      st_nxt.func = st_r.sw_sync[5:3];        // RL19
      st_nxt.state = MTR_ST_IDLE;
      st_nxt.ind.relay = 1'b0;
      st_nxt.sup_prev = 1'b0;
      tmr_stop = 1'b1;
    end else begin
      unique case (st_r.func)
        MTR_FN_MONITOR_POWER_ON: begin
          if (!sup_db) begin
            // Unpowered: relay drops, timing abandoned
            st_nxt.ind.relay = 1'b0;
            st_nxt.state = MTR_ST_IDLE;
            tmr_stop = 1'b1;
          end else if (sup_rise && ctrl_db) begin
            // Control already on at power-up
            st_nxt.ind.relay = 1'b1;          // RL1
            st_nxt.state = MTR_ST_TIMING;
            tmr_start = 1'b1;                 // RL1
          end else if (ctrl_rise) begin
            // Fresh edge retriggers, keeps relay on (RL4)
            st_nxt.ind.relay = 1'b1;          // RL3
            st_nxt.state = MTR_ST_TIMING;
            tmr_start = 1'b1;                 // RL3
          end else if (tmr_expire) begin
            // No edge in time
            st_nxt.ind.relay = 1'b0;          // RL2
            st_nxt.state = MTR_ST_IDLE;
          end
        end
        MTR_FN_PULSE_MONITOR_LATCHING: begin
          if (!sup_db) begin
            // Power loss clears the trip for the next power-up
            st_nxt.ind.relay = 1'b0;
            st_nxt.state = MTR_ST_IDLE;       // RL8
            tmr_stop = 1'b1;
          end else if (sup_rise) begin
            // Relay on before any control activity
            st_nxt.ind.relay = 1'b1;          // RL5
            st_nxt.state = MTR_ST_IDLE;
          end else if (st_r.state == MTR_ST_TRIPPED) begin
            // Tripped: control pulses have no effect
            st_nxt.ind.relay = 1'b0;          // RL8
          end else if (ctrl_rise) begin
            // Each closure starts the interval again
            st_nxt.state = MTR_ST_TIMING;
            tmr_start = 1'b1;                 // RL6
          end else if (tmr_expire) begin
            // Missed closure latches the relay off
            st_nxt.ind.relay = 1'b0;          // RL7
            st_nxt.state = MTR_ST_TRIPPED;    // RL7
          end
        end
        MTR_FN_ON_DELAY: begin
          if (!sup_db) begin
            // Loss forgets elapsed time
            st_nxt.ind.relay = 1'b0;
            st_nxt.state = MTR_ST_IDLE;
            tmr_stop = 1'b1;                  // RL10
          end else if (sup_rise) begin
            // Time from zero at each power-up
            st_nxt.ind.relay = 1'b0;
            st_nxt.state = MTR_ST_TIMING;
            tmr_start = 1'b1;                 // RL9
          end else if (tmr_expire) begin
            // On until supply goes
            st_nxt.ind.relay = 1'b1;          // RL9
            st_nxt.state = MTR_ST_IDLE;
          end
        end
        MTR_FN_OFF_DELAY: begin
          if (sup_db) begin
            // Powered: relay on, any interval cancelled
            st_nxt.ind.relay = 1'b1;          // RL11
            st_nxt.state = MTR_ST_IDLE;
            tmr_stop = 1'b1;                  // RL12
          end else if (sup_fall) begin
            // Time after power removal
            st_nxt.state = MTR_ST_TIMING;
            tmr_start = 1'b1;                 // RL11
          end else if (tmr_expire) begin
            // Interval over, relay drops
            st_nxt.ind.relay = 1'b0;          // RL11
            st_nxt.state = MTR_ST_IDLE;
          end
        end
        MTR_FN_POWER_LOSS_SINGLE_SHOT: begin
          if (tmr_expire) begin
            // Pulse ends whatever the supply
            st_nxt.ind.relay = 1'b0;          // RL13
            st_nxt.state = MTR_ST_IDLE;
          end
          if (sup_fall && !busy) begin
            // Supply return is not looked at while busy
            st_nxt.ind.relay = 1'b1;          // RL13
            st_nxt.state = MTR_ST_TIMING;     // RL14
            tmr_start = 1'b1;                 // RL21
          end
        end
        MTR_FN_POWER_GAIN_SINGLE_SHOT: begin
          if (tmr_expire) begin
            // Off until the next power-up
            st_nxt.ind.relay = 1'b0;          // RL15
            st_nxt.state = MTR_ST_IDLE;
          end
          if (sup_rise && !busy) begin
            // Dropout mid-pulse does not restart it
            st_nxt.ind.relay = 1'b1;          // RL15
            st_nxt.state = MTR_ST_TIMING;     // RL16
            tmr_start = 1'b1;                 // RL15
          end
        end
        MTR_FN_POWER_BOTH_EDGES_SINGLE_SHOT: begin
          if (tmr_expire) begin
            // Pulse over, wait for the next edge
            st_nxt.ind.relay = 1'b0;          // RL17
            st_nxt.state = MTR_ST_IDLE;
          end
          if ((sup_rise || sup_fall) && !busy) begin
            // Any supply edge fires, unless a pulse still runs
            st_nxt.ind.relay = 1'b1;          // RL17
            st_nxt.state = MTR_ST_TIMING;     // RL18
            tmr_start = 1'b1;                 // RL17
          end
        end
        default: begin
          // Unused switch position: relay held off
          st_nxt.ind.relay = 1'b0;
          st_nxt.state = MTR_ST_IDLE;
          tmr_stop = 1'b1;
        end
      endcase
    end

    // Flash phase steps only while an interval runs
    if (st_r.state != MTR_ST_TIMING) begin
      // Not timing: phase parked on the lit half
      st_nxt.flash = 1'b0;
      st_nxt.flash_cnt = '0;
    end else if (tmr_tick) begin
      if (st_r.flash_cnt == MTR_FL_W'(MTR_FLASH_MS - 1)) begin
        // Half period of ticks done, swap phase
        st_nxt.flash = ~st_r.flash;
        st_nxt.flash_cnt = '0;
      end else begin
        // Count another step
        st_nxt.flash_cnt = st_r.flash_cnt + MTR_FL_W'(1);
      end
    end

    // Lamps: flash when timing, steady with supply
    if (st_nxt.state == MTR_ST_TIMING) begin
      // Timing: lamp follows the flash phase
      st_nxt.ind.led_timing = ~st_nxt.flash;  // RL20
    end else begin
      // Idle: lamp shows the filtered supply
      st_nxt.ind.led_timing = sup_db;         // RL20
    end
    st_nxt.ind.led_output = st_nxt.ind.relay; // RL20
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset; function latched from switches afterwards
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.ind.relay <= MTR_RELAY_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Relay and lamps come straight from flops
  assign ind = st_r.ind;

endmodule : mtr_relay

//--- hw/mtr_pkg.sv
// Package: constants and types for the multi-function timing relay logic
package mtr_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int MTR_CLK_HZ = 10_000_000;     // Reference clock rate
  localparam int MTR_TICK_US = 1000;          // Timer step, 1 ms
  localparam int MTR_TICK_CYCLES =
    (MTR_CLK_HZ / 1_000_000) * MTR_TICK_US;   // Cycles per timer step
  localparam int MTR_DB_TIME_US = 10000;      // Debounce settle time
  localparam int MTR_DB_CYCLES =
    (MTR_CLK_HZ / 1_000_000) * MTR_DB_TIME_US; // Cycles to settle
  localparam int MTR_FLASH_MS = 250;          // Half period of flashing

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int MTR_PS_W = 16;               // Step prescaler width
  localparam int MTR_DB_W = 20;               // Debounce counter width
  localparam int MTR_CNT_W = 32;              // Elapsed ms counter width
  localparam int MTR_FL_W = 9;                // Flash counter width
  localparam logic MTR_RELAY_RST = 1'h0;      // Relay state after reset

  // ----------------------------------------------------------------
  // Selectable functions and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MTR_FN_MONITOR_POWER_ON = 3'h0,           // Edge monitor, on state
    MTR_FN_PULSE_MONITOR_LATCHING = 3'h1,     // Latching edge monitor
    MTR_FN_ON_DELAY = 3'h2,                   // Delay after power-up
    MTR_FN_OFF_DELAY = 3'h3,                  // Delay after power loss
    MTR_FN_POWER_LOSS_SINGLE_SHOT = 3'h4,     // Pulse at power loss
    MTR_FN_POWER_GAIN_SINGLE_SHOT = 3'h5,     // Pulse at power-up
    MTR_FN_POWER_BOTH_EDGES_SINGLE_SHOT = 3'h6 // Pulse at both
  } mtr_func_t;

  typedef enum logic [1:0] {
    MTR_ST_IDLE = 2'b00,                      // No interval running
    MTR_ST_TIMING = 2'b01,                    // Interval running
    MTR_ST_TRIPPED = 2'b10                    // Latched off
  } mtr_state_t;

  // Interval length in ms for each range switch position
  function automatic logic [MTR_CNT_W-1:0] mtr_range_ms(
    input logic [2:0] sel
  );
    case (sel)
      3'h0: mtr_range_ms = 32'h0000_0032;     // 50 ms
      3'h1: mtr_range_ms = 32'h0000_03E8;     // 1 s
      3'h2: mtr_range_ms = 32'h0000_2710;     // 10 s
      3'h3: mtr_range_ms = 32'h0000_EA60;     // 1 min
      3'h4: mtr_range_ms = 32'h0009_27C0;     // 10 min
      3'h5: mtr_range_ms = 32'h0036_EE80;     // 1 h
      3'h6: mtr_range_ms = 32'h1575_2A00;     // 100 h
      default: mtr_range_ms = 32'h0000_0032;  // Unused position
    endcase
  endfunction : mtr_range_ms

  // ----------------------------------------------------------------
  // Carriers and module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic relay;                              // Relay coil drive
    logic led_timing;                         // Supply / timing lamp
    logic led_output;                         // Output state lamp
  } mtr_ind_t;

  typedef struct packed {
    logic meta;                               // First sync stage
    logic sync;                               // Second sync stage
    logic stable;                             // Debounced level
    logic [MTR_DB_W-1:0] cnt;                 // Settle counter
  } mtr_db_st_t;

  typedef struct packed {
    logic running;                            // Interval in progress
    logic expire;                             // Expiry pulse
    logic tick;                               // 1 ms step pulse
    logic [MTR_PS_W-1:0] ps;                  // Step prescaler
    logic [MTR_CNT_W-1:0] cnt;                // Elapsed ms
  } mtr_tmr_st_t;

  typedef struct packed {
    mtr_state_t state;                        // Sequencer state
    mtr_ind_t ind;                            // Registered outputs
    logic sup_prev;                           // Last supply level
    logic ctrl_prev;                          // Last control level
    logic [5:0] sw_meta;                      // Switch first stage
    logic [5:0] sw_sync;                      // Switch second stage
    logic [2:0] func;                         // Active function code
    logic [2:0] range;                        // Active range code
    logic flash;                              // Flashing lamp phase
    logic [MTR_FL_W-1:0] flash_cnt;           // Flash step counter
  } mtr_top_st_t;

endpackage : mtr_pkg

//--- hw/mtr_debounce.sv
// Two-flop synchroniser with a debounce filter for one pin
`timescale 1ns/1ps
module mtr_debounce
  import mtr_pkg::*;
#(
  parameter int DB_CYCLES = MTR_DB_CYCLES     // Cycles a level must hold
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level
);

  mtr_db_st_t st_r;                           // Registered state
  mtr_db_st_t st_nxt;                         // Next state

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Sync the pin, then accept a new level only once it has held
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pin_in;
    st_nxt.sync = st_r.meta;
    if (st_r.sync == st_r.stable) begin
      // Level agrees, restart the settle count
      st_nxt.cnt = '0;
    end else if (st_r.cnt == MTR_DB_W'(DB_CYCLES - 1)) begin
      // Held long enough, take it
      st_nxt.stable = st_r.sync;
      st_nxt.cnt = '0;
    end else begin
      // Still settling
      st_nxt.cnt = st_r.cnt + MTR_DB_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset to a quiet low level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.stable;

endmodule : mtr_debounce

//--- hw/mtr_timer.sv
// Interval timer counting 1 ms steps up to a selected limit
`timescale 1ns/1ps
module mtr_timer
  import mtr_pkg::*;
#(
  parameter int TICK_CYCLES = MTR_TICK_CYCLES // Cycles per 1 ms step
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [MTR_CNT_W-1:0] limit_ms,
  output logic running,
  output logic expire,
  output logic ms_tick
);

  mtr_tmr_st_t st_r;                          // Registered state
  mtr_tmr_st_t st_nxt;                        // Next state

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Stop beats start; start always restarts from zero
  always_comb begin
    st_nxt = st_r;
    st_nxt.expire = 1'b0;
    st_nxt.tick = 1'b0;
    if (stop) begin
      // Abandon the interval, elapsed time is lost
      st_nxt.running = 1'b0;
      st_nxt.cnt = '0;
    end else if (start) begin
      // Fresh interval, prescaler aligned to the start
      st_nxt.running = 1'b1;
      st_nxt.ps = '0;
      st_nxt.cnt = '0;
    end else if (st_r.running) begin
      if (st_r.ps == MTR_PS_W'(TICK_CYCLES - 1)) begin
        // One more millisecond elapsed
        st_nxt.ps = '0;
        st_nxt.tick = 1'b1;
        st_nxt.cnt = st_r.cnt + MTR_CNT_W'(1);
        if (st_r.cnt + MTR_CNT_W'(1) >= limit_ms) begin
          // Interval complete
          st_nxt.running = 1'b0;
          st_nxt.expire = 1'b1;
        end
      end else begin
        st_nxt.ps = st_r.ps + MTR_PS_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset leaves the timer stopped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign running = st_r.running;
  assign expire = st_r.expire;
  assign ms_tick = st_r.tick;

endmodule : mtr_timer

//--- testbench/mtr_contact.sv
// Control contact model that chatters on every change
`timescale 1ns/1ps
module mtr_contact (
  input wire logic ref_clk,
  input wire logic close_cmd,
  output logic contact
);
  logic last_r; // Last commanded level
  logic [1:0] bnc_r; // Chatter cycles left
  initial begin
    last_r = 1'b0;
    bnc_r = 2'h0;
    contact = 1'b0;
  end
  // Chatter a few cycles, then settle on the command
  always @(posedge ref_clk) begin
    if (close_cmd != last_r) begin
      last_r <= close_cmd;
      bnc_r <= 2'h3;
    end else if (bnc_r != 2'h0) begin
      bnc_r <= bnc_r - 2'h1;
    end
    contact <= (bnc_r != 2'h0) ? ~contact : last_r;
  end
endmodule : mtr_contact

//--- testbench/mtr_relay_asserts.sv
// Port level checks of the timing relay sequencer
`timescale 1ns/1ps
module mtr_relay_asserts
  import mtr_pkg::*;
#(
  parameter int TICK_CYCLES = MTR_TICK_CYCLES, // Cycles per step
  parameter int DB_CYCLES = MTR_DB_CYCLES // Debounce cycles
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic supply_sense,
  input wire logic ctrl_in,
  input wire logic [2:0] func_sel,
  input wire logic [2:0] range_sel,
  input wire mtr_ind_t ind
);
  // ----------------------------------------
  // Helper conditions
  // ----------------------------------------
  wire mon_dark = func_sel == 3'h0 && !supply_sense; // Monitor unpowered
  wire ond_dark = func_sel == 3'h2 && !supply_sense; // On-delay unpowered
  wire off_lit = func_sel == 3'h3 && supply_sense; // Off-delay powered
  AST_LAMP_FOLLOW: assert property (
    @(posedge ref_clk) disable iff (rst) ind.led_output == ind.relay)
    else $error("output lamp differs from relay");
  AST_RST_CLEAR: assert property (
    @(posedge ref_clk) disable iff (rst) $past(rst) |-> ind == 3'h0)
    else $error("outputs not clear after reset");
  AST_MON_DARK: assert property (
    @(posedge ref_clk) disable iff (rst)
    mon_dark[*8] ##1 mon_dark[*8] |-> !ind.relay)
    else $error("monitor relay on without supply");
  AST_OND_DARK: assert property (
    @(posedge ref_clk) disable iff (rst)
    ond_dark[*8] ##1 ond_dark[*8] |-> !ind.relay)
    else $error("on-delay relay on without supply");
  AST_OND_LAMP: assert property (
    @(posedge ref_clk) disable iff (rst)
    ond_dark[*8] ##1 ond_dark[*8] |-> !ind.led_timing)
    else $error("timing lamp lit without supply");
  AST_OFF_LIT: assert property (
    @(posedge ref_clk) disable iff (rst)
    off_lit[*8] ##1 off_lit[*8] |-> ind.relay)
    else $error("off-delay relay off while powered");
  AST_UNUSED_OFF: assert property (
    @(posedge ref_clk) disable iff (rst)
    (func_sel == 3'h7)[*8] |-> !ind.relay)
    else $error("relay on in unused position");
  AST_OND_RISE: assert property (
    @(posedge ref_clk) disable iff (rst)
    func_sel == 3'h2 && $rose(ind.relay) |-> $past(supply_sense, 12))
    else $error("on-delay relay rose without supply");
endmodule : mtr_relay_asserts

bind mtr_relay mtr_relay_asserts #(
  .TICK_CYCLES(TICK_CYCLES),
  .DB_CYCLES(DB_CYCLES)
) mtr_relay_asserts_inst (
  .ref_clk(ref_clk), .rst(rst), .supply_sense(supply_sense),
  .ctrl_in(ctrl_in), .func_sel(func_sel), .range_sel(range_sel),
  .ind(ind)
);

//--- testbench/tb.sv
// Self-checking bench of the timing relay sequencer
`timescale 1ns/1ps
module tb
  import mtr_pkg::*;
;
  localparam int IV = 500; // 50 ms interval in cycles
  logic ref_clk = 1'b0; // 10 MHz clock
  logic rst = 1'b1; // Synchronous reset
  logic supply_sense = 1'b0; // Supply present
  logic close_cmd = 1'b0; // Contact command
  logic ctrl_in; // Contact as wired
  logic [2:0] func_sel = 3'h0; // Function switch
  logic [2:0] range_sel = 3'h0; // Range switch
  mtr_ind_t ind; // Relay and lamps
  int errors = 0;
  int compares = 0;
  initial forever #50 ref_clk = ~ref_clk;
  mtr_relay #(.TICK_CYCLES(10), .DB_CYCLES(4)) mtr_relay_inst (
    .ref_clk(ref_clk), .rst(rst), .supply_sense(supply_sense),
    .ctrl_in(ctrl_in), .func_sel(func_sel), .range_sel(range_sel),
    .ind(ind)
  );
  mtr_contact mtr_contact_inst (
    .ref_clk(ref_clk), .close_cmd(close_cmd), .contact(ctrl_in)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic sup(input logic v, input int n);
    @(posedge ref_clk);
    supply_sense <= v;
    cyc(n);
  endtask : sup
  task automatic con(input logic v, input int n);
    @(posedge ref_clk);
    close_cmd <= v;
    cyc(n);
  endtask : con
  task automatic chk(input logic seen, input logic exp);
    #10;
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Drop supply, pick switches, let old pulses end
  task automatic setup(input logic [2:0] f, input logic [2:0] r);
    @(posedge ref_clk);
    supply_sense <= 1'b0;
    close_cmd <= 1'b0;
    func_sel <= f;
    range_sel <= r;
    cyc(700);
  endtask : setup
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_monitor;
    setup(3'h0, 3'h0);
    con(1'b1, 20);
    sup(1'b1, 50);
    chk(ind.relay, 1'b1);
    cyc(IV);
    chk(ind.relay, 1'b0);
    con(1'b0, 50);
    con(1'b1, 50);
    chk(ind.relay, 1'b1);
    repeat (3) begin
      con(1'b0, 50);
      con(1'b1, 250);
    end
    chk(ind.relay, 1'b1);
    cyc(IV);
    chk(ind.relay, 1'b0);
    $display("monitor test done");
  endtask : t_monitor
  task automatic t_latch;
    setup(3'h1, 3'h0);
    sup(1'b1, 50);
    chk(ind.relay, 1'b1);
    cyc(700);
    chk(ind.relay, 1'b1);
    con(1'b1, 50);
    con(1'b0, 250);
    con(1'b1, 50);
    con(1'b0, 300);
    chk(ind.relay, 1'b1);
    cyc(300);
    chk(ind.relay, 1'b0);
    con(1'b1, 50);
    chk(ind.relay, 1'b0);
    con(1'b0, 50);
    chk(ind.relay, 1'b0);
    sup(1'b0, 50);
    sup(1'b1, 50);
    chk(ind.relay, 1'b1);
    $display("latching test done");
  endtask : t_latch
  task automatic t_ondelay;
    setup(3'h2, 3'h0);
    sup(1'b1, 200);
    sup(1'b0, 50);
    sup(1'b1, 450);
    chk(ind.relay, 1'b0);
    cyc(100);
    chk(ind.relay, 1'b1);
    chk(ind.led_timing, 1'b1);
    chk(ind.led_output, 1'b1);
    sup(1'b0, 50);
    chk(ind.relay, 1'b0);
    setup(3'h2, 3'h1);
    sup(1'b1, 3000);
    chk(ind.led_timing, 1'b0);
    cyc(6000);
    chk(ind.relay, 1'b0);
    cyc(1100);
    chk(ind.relay, 1'b1);
    $display("on-delay test done");
  endtask : t_ondelay
  task automatic t_offdelay;
    setup(3'h3, 3'h0);
    sup(1'b1, 50);
    chk(ind.relay, 1'b1);
    sup(1'b0, 300);
    chk(ind.relay, 1'b1);
    sup(1'b1, 50);
    sup(1'b0, 300);
    chk(ind.relay, 1'b1);
    cyc(250);
    chk(ind.relay, 1'b0);
    $display("off-delay test done");
  endtask : t_offdelay
  task automatic t_shots;
    setup(3'h4, 3'h0);
    sup(1'b1, 50);
    chk(ind.relay, 1'b0);
    sup(1'b0, 50);
    chk(ind.relay, 1'b1);
    sup(1'b1, 300);
    chk(ind.relay, 1'b1);
    cyc(200);
    chk(ind.relay, 1'b0);
    setup(3'h5, 3'h0);
    sup(1'b1, 50);
    chk(ind.relay, 1'b1);
    sup(1'b0, 50);
    sup(1'b1, 300);
    chk(ind.relay, 1'b1);
    cyc(160);
    chk(ind.relay, 1'b0);
    cyc(600);
    chk(ind.relay, 1'b0);
    setup(3'h6, 3'h0);
    sup(1'b1, 50);
    chk(ind.relay, 1'b1);
    cyc(IV);
    chk(ind.relay, 1'b0);
    sup(1'b0, 50);
    chk(ind.relay, 1'b1);
    sup(1'b1, 300);
    chk(ind.relay, 1'b1);
    cyc(200);
    chk(ind.relay, 1'b0);
    setup(3'h7, 3'h0);
    sup(1'b1, 50);
    chk(ind.relay, 1'b0);
    $display("single shot test done");
  endtask : t_shots
  // ----------------------------------------
  // Verdict and sequence
  // ----------------------------------------
  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    cyc(16);
    rst <= 1'b0;
    t_monitor;
    t_latch;
    t_ondelay;
    t_offdelay;
    t_shots;
    summarize;
  end
  // Watchdog well beyond the expected run
  initial begin
    cyc(40000);
    errors++;
    summarize;
  end
endmodule : tb
